/* File: src/gdpc_top.v */
// Gate driver protection control with AHB-Lite register slave
//
// Operation
// - Either supply in lockout holds gate low.
// - Gate high only when both supplies good.
// - Output supply lockout uses hysteresis comparator pair.
// - Lockout detection passes a deglitch filter.
// - Power-good open drain pulled low in lockout.
// - Lockout stops sense channel, output held low.
// - Open output supply enables active gate pulldown.
// - Clamp drive on when gate below threshold and output supply not open.
// - Overcurrent pin pulled low unless gate high.
// - Overcurrent evaluated only while gate is high.
// - Overcurrent starts two-level off, signals fault.
// - After fault, gate low until valid reset.
// - Mid level held fixed time, then soft off.
// - Fault output latched low until reset.
// - Reset requests ignored during fault mute time.
// - Floating reset/enable reads low, device disabled.
// - Long low reset clears fault on rise.
// - Reset/enable low gives regular turn-off.
// - Sense 0.6-4.5 V maps to 88-10 percent.
// - Floating sense gives 400 kHz, ten percent.
// - PWM and reset inputs pass 40 ns filter.
// - Floating PWM inputs hold gate low.
//
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "gdpc_defines.vh"

module gdpc_top #(
  parameter LOCKOUT_DEGLITCH_NS = `GDPC_LOCKOUT_DEGLITCH_NS,
  parameter MID_LEVEL_HOLD_NS   = `GDPC_MID_LEVEL_HOLD_NS,
  parameter FAULT_MUTE_NS       = `GDPC_FAULT_MUTE_NS,
  parameter RESET_FILTER_NS     = `GDPC_RESET_FILTER_NS
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire        pwm_in_pos,
  input  wire        pwm_in_neg,
  input  wire        pwm_inputs_float,
  input  wire        reset_enable_n,
  input  wire        vcc_above_lockout,
  input  wire        vdd_above_exit,
  input  wire        vdd_above_entry,
  input  wire        vdd_open,
  input  wire        gate_below_clamp,
  input  wire        gate_at_neg_rail,
  input  wire        overcurrent_above,
  input  wire [12:0] analog_sense_in,
  output reg         gate_drive_out,
  output reg         gate_regular_off,
  output reg         mid_level_en,
  output reg         soft_off_en,
  output reg         active_pulldown,
  output reg         clamp_drive,
  output reg         overcurrent_sense_pulldown,
  output wire        power_good_o,
  output reg         power_good_oe_n,
  output wire        fault_out_n_o,
  output reg         fault_out_n_oe_n,
  output wire        sensed_duty_out
);

  // ---------------------------------------------------------------
  // Cycle counts derived from times
  // ---------------------------------------------------------------
  localparam CLK_NS = `GDPC_CLK_PERIOD_NS;
  localparam IN_FILT_CYC =
    (`GDPC_INPUT_FILTER_NS + CLK_NS - 1) / CLK_NS;
  localparam LOCK_CYC = (LOCKOUT_DEGLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam MID_CYC  = (MID_LEVEL_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam MUTE_CYC = (FAULT_MUTE_NS + CLK_NS - 1) / CLK_NS;
  localparam RST_CYC  = (RESET_FILTER_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam SENSE_PERIOD = `GDPC_SENSE_PERIOD_NS / CLK_NS;

  localparam ST_OFF  = 3'h0;
  localparam ST_ON   = 3'h1;
  localparam ST_MID  = 3'h2;
  localparam ST_SOFT = 3'h3;
  localparam ST_HOLD = 3'h4;

  // ---------------------------------------------------------------
  // Pin filters
  // ---------------------------------------------------------------
  wire [3:0] ctl_f;
  wire [2:0] sup_f;
  wire [4:0] cmp_f;

  gdpc_pin_filter #(.WIDTH(4), .CYCLES(IN_FILT_CYC)) u_ctl_filt (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin     ({pwm_inputs_float, reset_enable_n, pwm_in_neg,
               pwm_in_pos}),
    .level   (ctl_f)
  );

  gdpc_pin_filter #(.WIDTH(3), .CYCLES(LOCK_CYC)) u_sup_filt (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin     ({vdd_above_entry, vdd_above_exit, vcc_above_lockout}),
    .level   (sup_f)
  );

  gdpc_pin_filter #(.WIDTH(5), .CYCLES(1)) u_cmp_filt (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin     ({overcurrent_above, gate_at_neg_rail, gate_below_clamp,
               vdd_open, 1'b0}),
    .level   (cmp_f)
  );

  wire in_pos   = ctl_f[0];
  wire in_neg   = ctl_f[1];
  wire rst_en   = ctl_f[2];
  wire in_float = ctl_f[3];
  wire vcc_ok   = sup_f[0];
  wire vdd_exit = sup_f[1];
  wire vdd_entr = sup_f[2];
  wire vdd_opn  = cmp_f[1];
  wire below_cl = cmp_f[2];
  wire at_rail  = cmp_f[3];
  wire oc_hit   = cmp_f[4];

  // ---------------------------------------------------------------
  // Registers and internal state
  // ---------------------------------------------------------------
  reg        ctrl_enable;
  reg        vdd_lock;
  reg        fault;
  reg [15:0] mute_cnt;
  reg [15:0] rst_cnt;
  reg        rst_armed;
  reg        rst_en_d;
  reg [2:0]  state;
  reg [15:0] mid_cnt;
  reg [12:0] sense1;
  reg [12:0] sense2;
  reg [12:0] sense3;
  reg [12:0] sense_mv;
  reg [6:0]  duty;
  reg        wr_pend;
  reg [3:0]  wr_addr;

  wire lockout  = !vcc_ok || vdd_lock;
  // Floating reset/enable reads low through the pulldown
  wire enabled  = rst_en && ctrl_enable;
  wire drive_rq = in_pos && !in_neg && !in_float;
  wire muted    = (mute_cnt != 16'h0000);
  wire gate_on  = (state == ST_ON) && !lockout && !vdd_opn;
  wire oc_event = gate_on && oc_hit;
  wire rst_rise = rst_en && !rst_en_d;
  wire fault_clr = rst_rise && rst_armed;

  // ---------------------------------------------------------------
  // Output supply lockout with hysteresis
  // ---------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vdd_lock <= 1'b1;
    end else if (!vdd_entr) begin
      vdd_lock <= 1'b1;
    end else if (vdd_exit) begin
      vdd_lock <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Fault latch, mute timer and reset qualification
  // ---------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault     <= 1'b0;
      mute_cnt  <= 16'h0000;
      rst_cnt   <= 16'h0000;
      rst_armed <= 1'b0;
      rst_en_d  <= 1'b0;
    end else begin
      rst_en_d <= rst_en;
      if (oc_event) begin
        fault     <= 1'b1;
        mute_cnt  <= MUTE_CYC[15:0];
        rst_armed <= 1'b0;
        rst_cnt   <= 16'h0000;
      end else begin
        if (fault_clr) begin
          fault <= 1'b0;
        end
        if (muted) begin
          mute_cnt <= mute_cnt - 16'h0001;
        end
        if (rst_en || muted) begin
          rst_cnt <= 16'h0000;
          if (rst_en) begin
            rst_armed <= 1'b0;
          end
        end else if (rst_cnt >= RST_CYC[15:0]) begin
          rst_armed <= fault;
        end else begin
          rst_cnt <= rst_cnt + 16'h0001;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Gate state machine
  // ---------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state   <= ST_OFF;
      mid_cnt <= 16'h0000;
    end else begin
      case (state)
        ST_OFF: begin
          // Both supplies good, enabled, no latched fault
          if (!lockout && enabled && drive_rq && !fault) begin
            state <= ST_ON;
          end
        end
        ST_ON: begin
          if (lockout) begin
            state <= ST_OFF;
          end else if (oc_event) begin
            state   <= ST_MID;
            mid_cnt <= 16'h0000;
          end else if (!enabled || !drive_rq) begin
            state <= ST_OFF;
          end
        end
        ST_MID: begin
          if (lockout) begin
            state <= ST_HOLD;
          end else if (mid_cnt >= MID_CYC[15:0] - 16'h0001) begin
            state <= ST_SOFT;
          end else begin
            mid_cnt <= mid_cnt + 16'h0001;
          end
        end
        ST_SOFT: begin
          if (at_rail || lockout) begin
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (!fault) begin
            state <= ST_OFF;
          end
        end
        default: begin
          state <= ST_OFF;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin drive outputs
  // ---------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_drive_out             <= 1'b0;
      gate_regular_off           <= 1'b1;
      mid_level_en               <= 1'b0;
      soft_off_en                <= 1'b0;
      active_pulldown            <= 1'b0;
      clamp_drive                <= 1'b0;
      overcurrent_sense_pulldown <= 1'b1;
      power_good_oe_n            <= 1'b0;
      fault_out_n_oe_n           <= 1'b1;
    end else begin
      gate_drive_out   <= gate_on;
      mid_level_en     <= (state == ST_MID);
      soft_off_en      <= (state == ST_SOFT);
      gate_regular_off <= (state == ST_OFF || state == ST_HOLD ||
                           lockout) && !vdd_opn;
      active_pulldown  <= vdd_opn;
      clamp_drive      <= below_cl && !vdd_opn;
      overcurrent_sense_pulldown <= !gate_on;
      power_good_oe_n  <= !lockout;
      fault_out_n_oe_n <= !fault;
    end
  end

  assign power_good_o  = 1'b0;
  assign fault_out_n_o = 1'b0;

  // ---------------------------------------------------------------
  // Sense channel: capture code, map to duty
  // ---------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sense1   <= 13'h0000;
      sense2   <= 13'h0000;
      sense3   <= 13'h0000;
      sense_mv <= 13'h0000;
      duty     <= `GDPC_DUTY_MIN_PCT;
    end else begin
      sense1 <= analog_sense_in;
      sense2 <= sense1;
      sense3 <= sense2;
      if (sense2 == sense3) begin
        sense_mv <= sense3;
      end
      if (sense_mv >= `GDPC_SENSE_MAX_MV) begin
        duty <= `GDPC_DUTY_MIN_PCT;
      end else if (sense_mv <= `GDPC_SENSE_MIN_MV) begin
        duty <= `GDPC_DUTY_MAX_PCT;
      end else begin
        duty <= `GDPC_DUTY_MIN_PCT + sense_step(sense_mv);
      end
    end
  end

  function [6:0] sense_step;
    input [12:0] mv;
    reg   [12:0] q;
    begin
      q = (`GDPC_SENSE_MAX_MV - mv) / `GDPC_MV_PER_PCT;
      sense_step = q[6:0];
    end
  endfunction

  gdpc_duty_gen #(.PERIOD(SENSE_PERIOD)) u_duty (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .run         (!lockout),
    .high_cycles (duty),
    .pwm         (sensed_duty_out)
  );

  // ---------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ---------------------------------------------------------------
  wire take   = hsel && hready && (htrans == `GDPC_HTRANS_NONSEQ);
  wire [31:0] status_word = {21'h000000, state, 1'b0, enabled,
                             (state == ST_ON), muted, fault,
                             vdd_lock, !vcc_ok, lockout};

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend     <= 1'b0;
      wr_addr     <= 4'h0;
      ctrl_enable <= `GDPC_CTRL_RESET;
      hrdata      <= 32'h0000_0000;
    end else begin
      wr_pend <= take && hwrite && (hsize == `GDPC_HSIZE_WORD);
      wr_addr <= haddr[3:0];
      if (wr_pend && wr_addr == `GDPC_ADDR_CTRL) begin
        ctrl_enable <= hwdata[`GDPC_CTRL_ENABLE];
      end
      if (take && !hwrite) begin
        case (haddr[11:0])
          {8'h00, `GDPC_ADDR_CTRL}: begin
            hrdata <= {31'h00000000, ctrl_enable};
          end
          {8'h00, `GDPC_ADDR_STATUS}: begin
            hrdata <= status_word;
          end
          {8'h00, `GDPC_ADDR_DUTY}: begin
            hrdata <= {25'h0000000, duty};
          end
          default: begin
            hrdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

/* File: src/gdpc_defines.vh */
// Constants shared by the gate driver protection control block
`ifndef GDPC_DEFINES_VH
`define GDPC_DEFINES_VH

// ---------------------------------------------------------------
// Clock and timing
// ---------------------------------------------------------------
`define GDPC_CLK_PERIOD_NS      25
`define GDPC_INPUT_FILTER_NS    40
`define GDPC_LOCKOUT_DEGLITCH_NS 1000
`define GDPC_MID_LEVEL_HOLD_NS  500
`define GDPC_FAULT_MUTE_NS      2000
`define GDPC_RESET_FILTER_NS    1000
`define GDPC_SENSE_PERIOD_NS    2500

// ---------------------------------------------------------------
// Analog sense to duty mapping (millivolts, percent)
// ---------------------------------------------------------------
`define GDPC_SENSE_MIN_MV       13'h0258
`define GDPC_SENSE_MAX_MV       13'h1194
`define GDPC_DUTY_MIN_PCT       7'h0A
`define GDPC_DUTY_MAX_PCT       7'h58
`define GDPC_MV_PER_PCT         13'h0032

// ---------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------
`define GDPC_ADDR_CTRL          4'h0
`define GDPC_ADDR_STATUS        4'h4
`define GDPC_ADDR_DUTY          4'h8

// ---------------------------------------------------------------
// Register fields
// ---------------------------------------------------------------
`define GDPC_CTRL_ENABLE        0
`define GDPC_CTRL_RESET         1'h1
`define GDPC_ST_LOCKOUT         0
`define GDPC_ST_VCC_LOCK        1
`define GDPC_ST_VDD_LOCK        2
`define GDPC_ST_FAULT           3
`define GDPC_ST_MUTE            4
`define GDPC_ST_GATE_HIGH       5
`define GDPC_ST_ENABLED         6
`define GDPC_ST_STATE_LSB       8

// ---------------------------------------------------------------
// AHB-Lite codes
// ---------------------------------------------------------------
`define GDPC_HTRANS_NONSEQ      2'h2
`define GDPC_HSIZE_WORD         3'h2

`endif

/* File: src/gdpc_pin_filter.v */
// Pin synchroniser with per-bit deglitch filter
`timescale 1ns/1ps
`default_nettype none

module gdpc_pin_filter #(
  parameter WIDTH  = 1,
  parameter CYCLES = 2
) (
  input  wire             hclk,
  input  wire             hresetn,
  input  wire [WIDTH-1:0] pin,
  output wire [WIDTH-1:0] level
);

  reg [WIDTH-1:0] sync1;
  reg [WIDTH-1:0] sync2;
  reg [WIDTH-1:0] sync3;

  // ---------------------------------------------------------------
  // Three flops; a change counts once stages two and three agree
  // ---------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= {WIDTH{1'b0}};
      sync2 <= {WIDTH{1'b0}};
      sync3 <= {WIDTH{1'b0}};
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // ---------------------------------------------------------------
  // Output follows only after the new level held CYCLES cycles
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg [15:0] cnt;
      reg        out;
      assign level[i] = out;
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cnt <= 16'h0000;
          out <= 1'b0;
        end else if (sync2[i] != sync3[i] || sync3[i] == out) begin
          cnt <= 16'h0000;
        end else if (cnt >= CYCLES[15:0] - 16'h0001) begin
          cnt <= 16'h0000;
          out <= sync3[i];
        end else begin
          cnt <= cnt + 16'h0001;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

/* File: src/gdpc_duty_gen.v */
// Fixed-period duty cycle generator for the sense channel
`timescale 1ns/1ps
`default_nettype none

module gdpc_duty_gen #(
  parameter PERIOD = 100
) (
  input  wire       hclk,
  input  wire       hresetn,
  input  wire       run,
  input  wire [6:0] high_cycles,
  output reg        pwm
);

  reg [6:0] cnt;

  // ---------------------------------------------------------------
  // Period counter; output forced low when stopped
  // ---------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 7'h00;
      pwm <= 1'b0;
    end else if (!run) begin
      cnt <= 7'h00;
      pwm <= 1'b0;
    end else begin
      if (cnt >= PERIOD[6:0] - 7'h01) begin
        cnt <= 7'h00;
      end else begin
        cnt <= cnt + 7'h01;
      end
      pwm <= (cnt < high_cycles);
    end
  end

endmodule

`default_nettype wire

/* File: bench/gdpc_chk.sv */
// Assertion checker bound to the gate driver protection control top
`timescale 1ns/1ps
`default_nettype none
module gdpc_chk #(
  parameter MID_LEVEL_HOLD_NS = 500
) (
  input wire hclk,
  input wire hresetn,
  input wire reset_enable_n,
  input wire pwm_inputs_float,
  input wire vdd_open,
  input wire gate_below_clamp,
  input wire gate_at_neg_rail,
  input wire gate_drive_out,
  input wire gate_regular_off,
  input wire mid_level_en,
  input wire soft_off_en,
  input wire active_pulldown,
  input wire clamp_drive,
  input wire overcurrent_sense_pulldown,
  input wire power_good_oe_n,
  input wire fault_out_n_oe_n,
  input wire sensed_duty_out
);
  localparam int MID_CYC = MID_LEVEL_HOLD_NS / 25;
  logic [7:0] mid_cnt;
  logic [5:0] open_cnt;
  logic [3:0] high_cnt;
  // ---------------------------------------------------------------
  // Helper counters
  // ---------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mid_cnt  <= 8'h00;
      open_cnt <= 6'h00;
      high_cnt <= 4'h0;
    end else begin
      mid_cnt  <= mid_level_en ? mid_cnt + 8'h01 : 8'h00;
      open_cnt <= !vdd_open ? 6'h00 : open_cnt + {5'h00, open_cnt != 6'h3F};
      high_cnt <= !reset_enable_n ? 4'h0 : high_cnt + {3'h0, high_cnt != 4'hF};
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_gate_lock: assert property (!power_good_oe_n && $past(!power_good_oe_n)
    |-> !gate_drive_out) else $error("gate high in lockout");
  a_duty_lock: assert property (!power_good_oe_n && $past(!power_good_oe_n)
    |-> !sensed_duty_out) else $error("duty output high in lockout");
  a_oc_pulldown: assert property (!gate_drive_out && $past(!gate_drive_out)
    |-> overcurrent_sense_pulldown) else $error("sense pulldown off");
  a_mid_hold: assert property ($fell(mid_level_en) && soft_off_en
    |-> mid_cnt == MID_CYC) else $error("mid level hold length wrong");
  a_soft_stop: assert property (gate_at_neg_rail [*8] |-> !soft_off_en)
    else $error("soft off past negative rail");
  a_fault_flag: assert property ($rose(mid_level_en)
    |-> ##[0:3] !fault_out_n_oe_n) else $error("no fault on two-level off");
  a_fault_gate: assert property (!fault_out_n_oe_n && $past(!fault_out_n_oe_n)
    |-> !gate_drive_out) else $error("gate high while fault latched");
  a_fault_latch: assert property (high_cnt == 4'hF && !fault_out_n_oe_n
    |=> !fault_out_n_oe_n) else $error("fault released without reset");
  a_clamp_on: assert property ((gate_below_clamp && !vdd_open
    && !gate_drive_out && power_good_oe_n) [*6] |-> clamp_drive)
    else $error("clamp drive off");
  a_open_pull: assert property (open_cnt == 6'h3F
    |-> active_pulldown && !gate_drive_out) else $error("no active pulldown");
  a_reg_off: assert property ((!reset_enable_n && !mid_level_en
    && !soft_off_en) [*8] |-> gate_regular_off && !gate_drive_out)
    else $error("disable without regular off");
  a_float_low: assert property (pwm_inputs_float [*8] |-> !gate_drive_out)
    else $error("gate high with floating inputs");
  c_soft: cover property ($rose(soft_off_en));
  c_clear: cover property ($rose(fault_out_n_oe_n));
  c_clamp: cover property ($rose(clamp_drive));
endmodule
bind gdpc_top gdpc_chk #(.MID_LEVEL_HOLD_NS(MID_LEVEL_HOLD_NS)) u_chk (
  .hclk, .hresetn, .reset_enable_n, .pwm_inputs_float, .vdd_open,
  .gate_below_clamp, .gate_at_neg_rail, .gate_drive_out, .gate_regular_off,
  .mid_level_en, .soft_off_en, .active_pulldown, .clamp_drive,
  .overcurrent_sense_pulldown, .power_good_oe_n, .fault_out_n_oe_n,
  .sensed_duty_out
);
`default_nettype wire

/* File: bench/gdpc_host_model.sv */
// Host controller model: input pins and open-drain pull-ups
`timescale 1ns/1ps
`default_nettype none
module gdpc_host_model (
  input  wire hclk,
  input  wire pwm_req,
  input  wire rst_req_n,
  input  wire float_pwm,
  input  wire float_rst,
  input  wire power_good_o,
  input  wire power_good_oe_n,
  input  wire fault_out_n_o,
  input  wire fault_out_n_oe_n,
  output reg  pwm_in_pos = 1'b0,
  output reg  pwm_in_neg = 1'b0,
  output reg  pwm_inputs_float = 1'b0,
  output reg  reset_enable_n = 1'b0,
  output wire power_good_line,
  output wire fault_line
);
  reg toggle = 1'b0;
  assign power_good_line = power_good_oe_n ? 1'b1 : power_good_o;
  assign fault_line = fault_out_n_oe_n ? 1'b1 : fault_out_n_o;
  always @(posedge hclk) begin
    toggle           <= ~toggle;
    pwm_in_pos       <= float_pwm ? toggle : pwm_req;
    pwm_in_neg       <= float_pwm ? ~toggle : 1'b0;
    pwm_inputs_float <= float_pwm;
    // Floating reset reads as the internal pulldown
    reset_enable_n   <= float_rst ? 1'b0 : rst_req_n;
  end
endmodule
`default_nettype wire

/* File: bench/gdpc_tb_top.sv */
// Self-checking testbench for the gate driver protection control block
`timescale 1ns/1ps
`default_nettype none
`include "gdpc_defines.vh"
module gdpc_tb_top;
  localparam MUTE_NS = 4000;
  reg         hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  reg  [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  reg  [1:0]  htrans = 2'h0;
  reg  [2:0]  hsize = 3'h2;
  reg         vcc_above_lockout = 1'b0, vdd_above_exit = 1'b0;
  reg         vdd_above_entry = 1'b0, vdd_open = 1'b0;
  reg         gate_below_clamp = 1'b1, gate_at_neg_rail = 1'b1;
  reg         overcurrent_above = 1'b0, pwm_req = 1'b0, rst_req_n = 1'b1;
  reg         float_pwm = 1'b0, float_rst = 1'b0;
  reg  [12:0] analog_sense_in = 13'h1388;
  wire        hready, hreadyout, hresp, pwm_in_pos, pwm_in_neg;
  wire        pwm_inputs_float, reset_enable_n, gate_drive_out;
  wire        gate_regular_off, mid_level_en, soft_off_en, active_pulldown;
  wire        clamp_drive, overcurrent_sense_pulldown, power_good_o;
  wire        power_good_oe_n, fault_out_n_o, fault_out_n_oe_n;
  wire        sensed_duty_out, power_good_line, fault_line;
  wire [31:0] hrdata;
  integer     mismatches = 0, samples_checked = 0, i, n;
  integer     mv_tab [0:3] = '{32'h258, 32'h9F6, 32'h1194, 32'h1388};
  assign hready = hreadyout;
  always #12.5 hclk = ~hclk;
  always @(posedge hclk) gate_below_clamp <= !gate_drive_out;
  gdpc_top #(.FAULT_MUTE_NS(MUTE_NS)) dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .pwm_in_pos, .pwm_in_neg,
    .pwm_inputs_float, .reset_enable_n, .vcc_above_lockout,
    .vdd_above_exit, .vdd_above_entry, .vdd_open, .gate_below_clamp,
    .gate_at_neg_rail, .overcurrent_above, .analog_sense_in,
    .gate_drive_out, .gate_regular_off, .mid_level_en, .soft_off_en,
    .active_pulldown, .clamp_drive, .overcurrent_sense_pulldown,
    .power_good_o, .power_good_oe_n, .fault_out_n_o, .fault_out_n_oe_n,
    .sensed_duty_out
  );
  gdpc_host_model host (
    .hclk, .pwm_req, .rst_req_n, .float_pwm, .float_rst, .power_good_o,
    .power_good_oe_n, .fault_out_n_o, .fault_out_n_oe_n, .pwm_in_pos,
    .pwm_in_neg, .pwm_inputs_float, .reset_enable_n, .power_good_line,
    .fault_line
  );
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input [31:0] seen, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ticks(input integer k);
    repeat (k) @(posedge hclk);
  endtask
  task automatic count_duty;
    n = 0;
    repeat (100) @(posedge hclk) n = n + sensed_duty_out;
  endtask
  task automatic ahb(input w, input [31:0] a, input [31:0] d,
                     output [31:0] q);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= `GDPC_HTRANS_NONSEQ;
    hwrite <= w;
    hsize  <= `GDPC_HSIZE_WORD;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  function automatic [31:0] duty_of(input integer mv);
    if (mv <= 32'h258) duty_of = 32'h58;
    else if (mv >= 32'h1194) duty_of = 32'hA;
    else duty_of = 32'hA + (32'h1194 - mv) / 32'h32;
  endfunction
  task automatic tally_and_finish;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    mismatches = mismatches + 1;
    tally_and_finish;
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    ticks(4);
    hresetn <= 1'b1;
    ticks(1);
    ahb(1'b0, `GDPC_ADDR_CTRL, 32'h0, rd);
    check(rd, 32'h1);
    ahb(1'b0, `GDPC_ADDR_STATUS, 32'h0, rd);
    check(rd[`GDPC_ST_LOCKOUT], 1'b1);
    check(power_good_line, 1'b0);
    ahb(1'b0, 32'hC, 32'h0, rd);
    check(rd, 32'h0);
    check({hreadyout, hresp}, 32'h2);
    pwm_req <= 1'b1;
    vcc_above_lockout <= 1'b1;
    vdd_above_exit <= 1'b1;
    vdd_above_entry <= 1'b1;
    ticks(10);
    check(gate_drive_out, 1'b0);
    ticks(50);
    check(gate_drive_out, 1'b1);
    check(power_good_line, 1'b1);
    check(overcurrent_sense_pulldown, 1'b0);
    pwm_req <= 1'b0;
    ticks(1);
    pwm_req <= 1'b1;
    ticks(10);
    check(gate_drive_out, 1'b1);
    pwm_req <= 1'b0;
    ticks(20);
    check(overcurrent_sense_pulldown, 1'b1);
    check(clamp_drive, 1'b1);
    pwm_req <= 1'b1;
    vdd_above_exit <= 1'b0;
    ticks(50);
    check(gate_drive_out, 1'b1);
    vdd_above_entry <= 1'b0;
    ticks(5);
    vdd_above_entry <= 1'b1;
    ticks(10);
    check(power_good_line, 1'b1);
    vdd_above_entry <= 1'b0;
    ticks(50);
    check(power_good_line, 1'b0);
    vdd_above_entry <= 1'b1;
    ticks(50);
    check(gate_drive_out, 1'b0);
    vdd_above_exit <= 1'b1;
    ticks(50);
    check(gate_drive_out, 1'b1);
    vcc_above_lockout <= 1'b0;
    ticks(50);
    check(gate_drive_out, 1'b0);
    count_duty;
    check(n, 32'h0);
    vcc_above_lockout <= 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      analog_sense_in <= mv_tab[i][12:0];
      ticks(250);
      count_duty;
      check(n, duty_of(mv_tab[i]));
      ahb(1'b0, `GDPC_ADDR_DUTY, 32'h0, rd);
      check(rd, duty_of(mv_tab[i]));
    end
    ahb(1'b1, `GDPC_ADDR_CTRL, 32'h0, rd);
    ticks(10);
    check(gate_regular_off, 1'b1);
    ahb(1'b1, `GDPC_ADDR_CTRL, 32'h1, rd);
    rst_req_n <= 1'b0;
    ticks(10);
    check(gate_drive_out, 1'b0);
    check(gate_regular_off, 1'b1);
    float_rst <= 1'b1;
    rst_req_n <= 1'b1;
    ticks(10);
    check(gate_drive_out, 1'b0);
    float_rst <= 1'b0;
    float_pwm <= 1'b1;
    ticks(10);
    check(gate_drive_out, 1'b0);
    float_pwm <= 1'b0;
    ticks(10);
    check(gate_drive_out, 1'b1);
    gate_at_neg_rail <= 1'b0;
    overcurrent_above <= 1'b1;
    ticks(8);
    check(mid_level_en, 1'b1);
    check(fault_line, 1'b0);
    ticks(22);
    check(soft_off_en, 1'b1);
    gate_at_neg_rail <= 1'b1;
    overcurrent_above <= 1'b0;
    ticks(3);
    rst_req_n <= 1'b0;
    ticks(60);
    rst_req_n <= 1'b1;
    ticks(10);
    check(fault_line, 1'b0);
    check(gate_drive_out, 1'b0);
    ticks(70);
    rst_req_n <= 1'b0;
    ticks(20);
    rst_req_n <= 1'b1;
    ticks(10);
    check(fault_line, 1'b0);
    rst_req_n <= 1'b0;
    ticks(60);
    check(fault_line, 1'b0);
    rst_req_n <= 1'b1;
    ticks(10);
    check(fault_line, 1'b1);
    vdd_open <= 1'b1;
    ticks(70);
    check(active_pulldown, 1'b1);
    tally_and_finish;
  end
endmodule
`default_nettype wire
